// >>> rtl/sdi_apb_regs.sv
// apb slave holding the control word and showing device status
`include "sdi_defs.svh"
module sdi_apb_regs (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_cke,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] i_status,
   input wire logic [`SDI_MODE_W-1:0] i_mode,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_ctrl
);
   logic setup;
   logic hit;
   logic [31:0] rd_mux;

   assign setup = i_psel && !i_penable;

   always_comb
   begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (i_paddr)
         `SDI_REG_CTRL: rd_mux = o_ctrl;
         `SDI_REG_STATUS: rd_mux = i_status;
         `SDI_REG_MODE: rd_mux = {{(32-`SDI_MODE_W){1'b0}}, i_mode};
         default: hit = 1'b0;
      endcase
   end

   // answer is prepared in the setup cycle so pready is high in the first access cycle
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end
      else if (i_cke)
      begin
         o_pready <= setup;
         o_pslverr <= setup && !hit;
         o_prdata <= (setup && !i_pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         o_ctrl <= `SDI_CTRL_RST;
      end
      else if (i_cke && i_psel && i_penable && o_pready && i_pwrite
               && i_paddr == `SDI_REG_CTRL)
      begin
         o_ctrl <= i_pwdata & `SDI_CTRL_MASK;
      end
   end
endmodule // sdi_apb_regs

// >>> rtl/sdi_core.sv
// quad-bank sdram device: command decode, bank rows, bursts, byte masks, status over apb
//
// Chosen here: register access over APB and the placing of the registers.
`include "sdi_defs.svh"
module sdi_core #(
   parameter int ROW_W = `SDI_ROW_W,
   parameter int COL_W = `SDI_COL_W
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_cke,
   input wire logic i_cs_n,
   input wire logic i_ras_n,
   input wire logic i_cas_n,
   input wire logic i_we_n,
   input wire sdi_pkg::sdi_bank_t i_bank_select,
   input wire logic [11:0] i_row_col_address,
   input wire sdi_pkg::sdi_lanes_t i_byte_lane_mask,
   input wire logic [31:0] i_data_lines,
   output logic [31:0] o_data_lines,
   output sdi_pkg::sdi_lanes_t o_data_lines_oe,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);
   import sdi_pkg::*;

   localparam int MEM_AW = 2 + ROW_W + COL_W;

   logic [3:0] cmd;
   logic is_act, is_rd, is_wr, is_pre, is_ref, is_lmr, is_bst;
   logic rw_ok, new_rd, new_wr, new_rw;
   logic [31:0] ctrl;
   logic [31:0] status;
   logic [`SDI_MODE_W-1:0] mode_q;
   logic mode_loaded_q, all_pre_q, init_done_q;
   logic [1:0] ref_cnt_q;
   logic [3:0] bank_open_q;
   logic [ROW_W-1:0] row_q [`SDI_BANKS];
   sdi_burst_t state_q;
   sdi_bank_t b_bank_q;
   logic [COL_W-1:0] b_start_q, b_idx_q, b_lm_q;
   logic b_ap_q, b_full_q;
   logic [COL_W-1:0] mode_lm, new_lm, cur_start, cur_idx, cur_lm, offs, col;
   logic mode_full, cur_full, cur_ap, ilv, cont, beat_last, done, pre_hit;
   sdi_bank_t cur_bank;
   logic rd_beat, wr_beat;
   logic [MEM_AW-1:0] mem_addr;
   sdi_lanes_t mem_be, mask_d1_q;
   logic [31:0] mem_rdata, rd2_q, out_d;
   logic rv1_q, rv2_q, out_v, cl3;

   // chip select high gives a code with bit 3 set, which matches no command
   assign cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
   assign is_act = i_cke && cmd == `SDI_CMD_ACT;
   assign is_rd = i_cke && cmd == `SDI_CMD_RD;
   assign is_wr = i_cke && cmd == `SDI_CMD_WR;
   assign is_pre = i_cke && cmd == `SDI_CMD_PRE;
   assign is_ref = i_cke && cmd == `SDI_CMD_REF;
   assign is_lmr = i_cke && cmd == `SDI_CMD_LMR;
   assign is_bst = i_cke && cmd == `SDI_CMD_BST;

   // optional gate: software may refuse data commands until start-up is complete
   assign rw_ok = !(ctrl[`SDI_CTRL_GATE_BIT] && !init_done_q);
   assign new_rd = is_rd && rw_ok;
   assign new_wr = is_wr && rw_ok;
   assign new_rw = new_rd || new_wr;

   always_comb
   begin
      mode_full = 1'b0;
      case (mode_q[2:0])
         `SDI_BL_2: mode_lm = 9'h001;
         `SDI_BL_4: mode_lm = 9'h003;
         `SDI_BL_8: mode_lm = 9'h007;
         `SDI_BL_FULL:
         begin
            mode_lm = 9'h1FF;
            mode_full = 1'b1;
         end
         default: mode_lm = 9'h000;
      endcase
   end

   // single-location write mode shortens write bursts to one word
   assign new_lm = (new_wr && mode_q[`SDI_MODE_WBM_BIT]) ? 9'h000 : mode_lm;
   assign cur_start = new_rw ? i_row_col_address[COL_W-1:0] : b_start_q;
   assign cur_idx = new_rw ? 9'h000 : b_idx_q;
   assign cur_lm = new_rw ? new_lm : b_lm_q;
   assign cur_full = new_rw ? (mode_full && new_lm == mode_lm) : b_full_q;
   assign cur_ap = new_rw ? i_row_col_address[`SDI_AP_BIT] : b_ap_q;
   assign cur_bank = new_rw ? i_bank_select : b_bank_q;
   // interleaved order has no full-page form, so full page is always sequential
   assign ilv = mode_q[`SDI_MODE_BT_BIT] && !mode_full;
   assign offs = ilv ? (cur_start ^ cur_idx) : COL_W'(cur_start + cur_idx);
   assign col = (cur_start & ~cur_lm) | (offs & cur_lm);

   assign pre_hit = is_pre && (i_row_col_address[`SDI_AP_BIT] || i_bank_select == b_bank_q);
   assign cont = i_cke && state_q != SDI_IDLE && !new_rw && !is_bst && !pre_hit;
   assign rd_beat = new_rd || (cont && state_q == SDI_READ);
   assign wr_beat = new_wr || (cont && state_q == SDI_WRITE);
   assign beat_last = !cur_full && cur_idx == cur_lm;
   assign done = (new_rw || cont) && beat_last;

   assign mem_addr = {cur_bank, row_q[cur_bank], col};
   assign mem_be = wr_beat ? ~i_byte_lane_mask : 4'h0;

   sdi_mem #(
      .ADDR_W(MEM_AW),
      .DATA_W(32)
   ) u_mem (
      .i_mclk(i_mclk),
      .i_cke(i_cke),
      .i_addr(mem_addr),
      .i_be(mem_be),
      .i_wdata(i_data_lines),
      .o_rdata(mem_rdata)
   );

   // burst engine: a new read or write cuts off a running burst
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         state_q <= SDI_IDLE;
         b_bank_q <= 2'h0;
         b_start_q <= 9'h000;
         b_idx_q <= 9'h000;
         b_lm_q <= 9'h000;
         b_ap_q <= 1'b0;
         b_full_q <= 1'b0;
      end
      else if (i_cke)
      begin
         if (new_rw)
         begin
            state_q <= beat_last ? SDI_IDLE : (new_rd ? SDI_READ : SDI_WRITE);
            b_bank_q <= i_bank_select;
            b_start_q <= i_row_col_address[COL_W-1:0];
            b_idx_q <= 9'h001;
            b_lm_q <= new_lm;
            b_ap_q <= i_row_col_address[`SDI_AP_BIT];
            b_full_q <= cur_full;
         end
         else if (state_q != SDI_IDLE)
         begin
            if (!cont || done)
            begin
               state_q <= SDI_IDLE;
            end
            b_idx_q <= COL_W'(b_idx_q + 9'h001);
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < `SDI_BANKS; g++)
      begin : g_bank
         always_ff @(posedge i_mclk)
         begin
            if (i_reset)
            begin
               bank_open_q[g] <= 1'b0;
               row_q[g] <= '0;
            end
            else if (i_cke)
            begin
               if (is_act && i_bank_select == 2'(g))
               begin
                  bank_open_q[g] <= 1'b1;
                  row_q[g] <= i_row_col_address[ROW_W-1:0];
               end
               else if (is_pre && (i_row_col_address[`SDI_AP_BIT] || i_bank_select == 2'(g)))
               begin
                  bank_open_q[g] <= 1'b0;
               end
               else if (done && cur_ap && cur_bank == 2'(g))
               begin
                  bank_open_q[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // start-up tracking: precharge all, then refreshes, then mode load
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         mode_q <= `SDI_MODE_RST;
         mode_loaded_q <= 1'b0;
         all_pre_q <= 1'b0;
         ref_cnt_q <= 2'h0;
         init_done_q <= 1'b0;
      end
      else if (i_cke)
      begin
         if (is_lmr)
         begin
            mode_q <= {i_bank_select, i_row_col_address};
            mode_loaded_q <= 1'b1;
            if (ref_cnt_q >= `SDI_REFRESH_NEEDED)
            begin
               init_done_q <= 1'b1;
            end
         end
         if (is_pre && i_row_col_address[`SDI_AP_BIT])
         begin
            all_pre_q <= 1'b1;
            ref_cnt_q <= 2'h0;
         end
         else if (is_ref && all_pre_q && ref_cnt_q != 2'h3)
         begin
            ref_cnt_q <= 2'(ref_cnt_q + 2'h1);
         end
      end
   end

   // latency 1 is served as 2: the array read is registered before the output flop
   assign cl3 = mode_q[6:4] == `SDI_CL_3;
   assign out_v = cl3 ? rv2_q : rv1_q;
   assign out_d = cl3 ? rd2_q : mem_rdata;

   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         rv1_q <= 1'b0;
         rv2_q <= 1'b0;
         rd2_q <= 32'h0000_0000;
         mask_d1_q <= 4'hF;
         o_data_lines <= 32'h0000_0000;
      end
      else if (i_cke)
      begin
         rv1_q <= rd_beat;
         rv2_q <= rv1_q;
         rd2_q <= mem_rdata;
         mask_d1_q <= i_byte_lane_mask;
         o_data_lines <= out_d;
      end
   end

   generate
      for (g = 0; g < 4; g++)
      begin : g_lane
         always_ff @(posedge i_mclk)
         begin
            if (i_reset)
            begin
               o_data_lines_oe[g] <= 1'b0;
            end
            else if (i_cke)
            begin
               o_data_lines_oe[g] <= out_v && !mask_d1_q[g];
            end
         end
      end
   endgenerate

   assign status = {22'h0, state_q != SDI_IDLE, init_done_q, mode_loaded_q, ref_cnt_q,
                    bank_open_q == 4'h0, bank_open_q};

   sdi_apb_regs u_regs (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_cke(i_cke),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_paddr(i_paddr),
      .i_pwdata(i_pwdata),
      .i_status(status),
      .i_mode(mode_q),
      .o_prdata(o_prdata),
      .o_pready(o_pready),
      .o_pslverr(o_pslverr),
      .o_ctrl(ctrl)
   );

   property p_cmd_masked;
      @(posedge i_mclk) disable iff (i_reset)
      // a running burst with auto precharge may still close its bank
      (i_cs_n && !done) |=> $stable(bank_open_q) && $stable(mode_q);
   endproperty
   a_cmd_masked: assert property (p_cmd_masked) else $error("masked command changed state");

   property p_act_row;
      @(posedge i_mclk) disable iff (i_reset)
      is_act |=> bank_open_q[$past(i_bank_select)]
                 && row_q[$past(i_bank_select)] == $past(i_row_col_address);
   endproperty
   a_act_row: assert property (p_act_row) else $error("activate did not open row");

   property p_pre_all;
      @(posedge i_mclk) disable iff (i_reset)
      (is_pre && i_row_col_address[`SDI_AP_BIT]) |=> bank_open_q == 4'h0;
   endproperty
   a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

   property p_pre_one;
      @(posedge i_mclk) disable iff (i_reset)
      (is_pre && !i_row_col_address[`SDI_AP_BIT] && !is_act)
      |=> !bank_open_q[$past(i_bank_select)];
   endproperty
   a_pre_one: assert property (p_pre_one) else $error("bank precharge missed bank");

   property p_lmr;
      @(posedge i_mclk) disable iff (i_reset)
      is_lmr |=> mode_q == {$past(i_bank_select), $past(i_row_col_address)};
   endproperty
   a_lmr: assert property (p_lmr) else $error("mode code not loaded");

   property p_wr_mask;
      @(posedge i_mclk) disable iff (i_reset)
      (wr_beat && i_byte_lane_mask[2]) |-> !mem_be[2] && mem_be[0] == !i_byte_lane_mask[0];
   endproperty
   a_wr_mask: assert property (p_wr_mask) else $error("masked byte written");

   property p_start_col;
      @(posedge i_mclk) disable iff (i_reset)
      new_rw |-> mem_addr[COL_W-1:0] == i_row_col_address[COL_W-1:0];
   endproperty
   a_start_col: assert property (p_start_col) else $error("wrong start column");

   property p_burst_seq;
      @(posedge i_mclk) disable iff (i_reset)
      (new_wr && mode_q[2:0] == `SDI_BL_4 && !mode_q[`SDI_MODE_BT_BIT]
       && !mode_q[`SDI_MODE_WBM_BIT]) ##1 (i_cke && !new_rw && !is_bst && !is_pre)
      |-> wr_beat && mem_addr[1:0] == 2'($past(i_row_col_address[1:0]) + 2'h1)
          && mem_addr[8:2] == $past(i_row_col_address[8:2]);
   endproperty
   a_burst_seq: assert property (p_burst_seq) else $error("burst order wrong");

   property p_auto_pre;
      @(posedge i_mclk) disable iff (i_reset)
      (new_wr && i_row_col_address[`SDI_AP_BIT] && mode_q[2:0] == `SDI_BL_2
       && !mode_q[`SDI_MODE_WBM_BIT]) ##1 (i_cke && !new_rw && !is_bst && !is_pre && !is_act)
      |=> !bank_open_q[$past(i_bank_select, 2)];
   endproperty
   a_auto_pre: assert property (p_auto_pre) else $error("auto precharge missed");

   property p_mask_float;
      @(posedge i_mclk) disable iff (i_reset)
      (i_cke && i_byte_lane_mask[1]) ##1 i_cke |=> !o_data_lines_oe[1];
   endproperty
   a_mask_float: assert property (p_mask_float) else $error("masked lane driven");

   property p_read_cl2;
      @(posedge i_mclk) disable iff (i_reset)
      (new_rd && mode_q[6:4] == `SDI_CL_2 && i_byte_lane_mask == 4'h0) ##1 i_cke
      |=> o_data_lines_oe == 4'hF;
   endproperty
   a_read_cl2: assert property (p_read_cl2) else $error("read data not driven");
endmodule // sdi_core

// >>> rtl/sdi_defs.svh
// constants of the sdram device model: command codes, fields, register map
`ifndef SDI_DEFS_SVH
`define SDI_DEFS_SVH

// command codes as {cs_n, ras_n, cas_n, we_n}
`define SDI_CMD_LMR 4'h0
`define SDI_CMD_REF 4'h1
`define SDI_CMD_PRE 4'h2
`define SDI_CMD_ACT 4'h3
`define SDI_CMD_WR 4'h4
`define SDI_CMD_RD 4'h5
`define SDI_CMD_BST 4'h6

// array geometry and address bit positions
`define SDI_BANKS 4
`define SDI_ROW_W 12
`define SDI_COL_W 9
`define SDI_AP_BIT 10

// mode register: bits 11:0 from the address lines, 13:12 from bank select
`define SDI_MODE_W 14
`define SDI_MODE_RST 14'h0000
`define SDI_MODE_BT_BIT 3
`define SDI_MODE_WBM_BIT 9
`define SDI_BL_1 3'h0
`define SDI_BL_2 3'h1
`define SDI_BL_4 3'h2
`define SDI_BL_8 3'h3
`define SDI_BL_FULL 3'h7
`define SDI_CL_2 3'h2
`define SDI_CL_3 3'h3

// apb register byte offsets
`define SDI_REG_CTRL 8'h00
`define SDI_REG_STATUS 8'h04
`define SDI_REG_MODE 8'h08
`define SDI_CTRL_RST 32'h0000_0000
`define SDI_CTRL_MASK 32'h0000_0001
`define SDI_CTRL_GATE_BIT 0

// status layout
`define SDI_ST_ALLIDLE_BIT 4
`define SDI_ST_MODE_BIT 7
`define SDI_ST_INIT_BIT 8
`define SDI_ST_BURST_BIT 9
`define SDI_REFRESH_NEEDED 2'h2

`endif

// >>> rtl/sdi_mem.sv
// word array with byte-lane write enables and a registered read port
module sdi_mem #(
   parameter int ADDR_W = 23,
   parameter int DATA_W = 32
) (
   input wire logic i_mclk,
   input wire logic i_cke,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W/8-1:0] i_be,
   input wire logic [DATA_W-1:0] i_wdata,
   output logic [DATA_W-1:0] o_rdata
);
   logic [DATA_W-1:0] mem_q [2**ADDR_W];

   // one process owns the array: lanes of one word share a variable index
   always_ff @(posedge i_mclk)
   begin
      if (i_cke)
      begin
         for (int k = 0; k < DATA_W/8; k++)
         begin
            if (i_be[k])
            begin
               mem_q[i_addr][8*k +: 8] <= i_wdata[8*k +: 8];
            end
         end
      end
   end

   // read returns the old word when the same address is written
   always_ff @(posedge i_mclk)
   begin
      if (i_cke)
      begin
         o_rdata <= mem_q[i_addr];
      end
   end
endmodule // sdi_mem

// >>> rtl/sdi_pkg.sv
// types shared by the sdram device model
package sdi_pkg;
   typedef enum logic [1:0] {SDI_IDLE, SDI_READ, SDI_WRITE} sdi_burst_t;
   typedef logic [3:0] sdi_lanes_t;
   typedef logic [1:0] sdi_bank_t;
endpackage

// >>> sim/sdi_ctrl_model.sv
// memory controller model driving the sdram command, address, mask and write-data pins
`include "sdi_defs.svh"
module sdi_ctrl_model (
   input wire logic i_mclk,
   output logic o_cs_n,
   output logic o_ras_n,
   output logic o_cas_n,
   output logic o_we_n,
   output sdi_pkg::sdi_bank_t o_bank_select,
   output logic [11:0] o_row_col_address,
   output sdi_pkg::sdi_lanes_t o_byte_lane_mask,
   output logic [31:0] o_data_lines
);
   timeunit 1ns;
   timeprecision 1ns;
   import sdi_pkg::*;
   localparam logic [3:0] NOP = 4'h7;
   localparam logic [3:0] INHIBIT = 4'h8;
   initial
   begin
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = INHIBIT;
      o_bank_select = 2'h0;
      o_row_col_address = 12'h000;
      o_byte_lane_mask = 4'h0;
      o_data_lines = 32'h0000_0000;
   end
   // launched after one edge, sampled at the next
   task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
      input logic [3:0] m, input logic [31:0] d, input bit dv);
   begin
      @(posedge i_mclk);
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= c;
      o_bank_select <= b;
      o_row_col_address <= a;
      o_byte_lane_mask <= m;
      // a released data bus flips rather than holding a stale word
      o_data_lines <= dv ? d : ~o_data_lines;
   end
   endtask
   task automatic nop(input int n);
   begin
      repeat (n) cmd(NOP, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
   end
   endtask
   task automatic power_up(input int wait_cycles, input logic [13:0] mode);
   begin
      for (int i = 0; i < wait_cycles; i++)
         cmd(i[0] ? NOP : INHIBIT, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
      cmd(`SDI_CMD_PRE, 2'h0, 12'h400, 4'h0, 32'h0, 1'b0);
      nop(2);
      repeat (2)
      begin
         cmd(`SDI_CMD_REF, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
         nop(8);
      end
      cmd(`SDI_CMD_LMR, mode[13:12], mode[11:0], 4'h0, 32'h0, 1'b0);
      nop(2);
   end
   endtask
endmodule // sdi_ctrl_model

// >>> sim/sdram_init_and_addressing_bench.sv
// self-checking bench for the sdram device model
`include "sdi_defs.svh"
module sdram_init_and_addressing_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import sdi_pkg::*;
   typedef struct {
      logic [1:0] b;
      logic [11:0] row;
      logic [8:0] col;
      logic [3:0] wm;
      logic [31:0] wd;
      logic [3:0] rm;
      logic [31:0] ex;
   } sdi_case_t;
   localparam logic [3:0] NOP = 4'h7;
   logic i_mclk = 1'b0;
   logic i_reset = 1'b1;
   logic i_cke = 1'b1;
   logic i_cs_n, i_ras_n, i_cas_n, i_we_n;
   sdi_bank_t i_bank_select;
   logic [11:0] i_row_col_address;
   sdi_lanes_t i_byte_lane_mask;
   logic [31:0] i_data_lines, o_data_lines;
   sdi_lanes_t o_data_lines_oe;
   logic i_psel, i_penable, i_pwrite;
   logic [7:0] i_paddr;
   logic [31:0] i_pwdata;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr;
   int n_mismatch = 0;
   int check_count = 0;
   logic [31:0] d4 [4] = '{32'h0101_1010, 32'h2323_3232, 32'h4545_5454, 32'h6767_7676};
   sdi_case_t cases [5] = '{
      '{2'h0, 12'h000, 9'h000, 4'h0, 32'h1122_3344, 4'h0, 32'h1122_3344},
      '{2'h1, 12'hFFF, 9'h1FF, 4'h1, 32'h1122_3344, 4'h0, 32'h1122_33A5},
      '{2'h2, 12'h555, 9'h0AA, 4'h6, 32'hDEAD_BEEF, 4'h1, 32'hDEA5_A5EF},
      '{2'h3, 12'hAAA, 9'h155, 4'h8, 32'hDEAD_BEEF, 4'hA, 32'hA5AD_BEEF},
      '{2'h0, 12'h001, 9'h000, 4'hF, 32'h0000_0000, 4'hF, 32'hA5A5_A5A5}};
   always #25 i_mclk = ~i_mclk;
   sdi_core uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_cke(i_cke), .i_cs_n(i_cs_n),
      .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_bank_select(i_bank_select),
      .i_row_col_address(i_row_col_address), .i_byte_lane_mask(i_byte_lane_mask),
      .i_data_lines(i_data_lines), .o_data_lines(o_data_lines),
      .o_data_lines_oe(o_data_lines_oe), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr));
   sdi_ctrl_model ctl (.i_mclk(i_mclk), .o_cs_n(i_cs_n), .o_ras_n(i_ras_n),
      .o_cas_n(i_cas_n), .o_we_n(i_we_n), .o_bank_select(i_bank_select),
      .o_row_col_address(i_row_col_address), .o_byte_lane_mask(i_byte_lane_mask),
      .o_data_lines(i_data_lines));
   function automatic logic [31:0] lanes(input logic [3:0] m);
      return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
   endfunction
   task automatic conclude();
   begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
   begin
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   end
   endtask
   task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
   begin
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge i_mclk);
         n++;
      end
      while (o_pready !== 1'b1);
      r = o_prdata;
      e = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      chk("apb_wait", 32'h1, 32'(n));
   end
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp);
      logic [31:0] r;
      logic e;
   begin
      apb(1'b0, a, 32'h0, r, e);
      chk(what, exp, r & m);
   end
   endtask
   task automatic act(input logic [1:0] b, input logic [11:0] row);
   begin
      ctl.cmd(`SDI_CMD_ACT, b, row, 4'h0, 32'h0, 1'b0);
      ctl.nop(1);
   end
   endtask
   task automatic pre(input logic [1:0] b, input bit all);
   begin
      ctl.cmd(`SDI_CMD_PRE, b, all ? 12'h400 : 12'h000, 4'h0, 32'h0, 1'b0);
      ctl.nop(1);
   end
   endtask
   task automatic lmr(input logic [13:0] mode);
   begin
      pre(2'h0, 1'b1);
      ctl.cmd(`SDI_CMD_LMR, mode[13:12], mode[11:0], 4'h0, 32'h0, 1'b0);
      ctl.nop(2);
   end
   endtask
   task automatic wr(input logic [1:0] b, input logic [11:0] a, input logic [3:0] m,
      input int n, input logic [31:0] d [4]);
   begin
      ctl.cmd(`SDI_CMD_WR, b, a, m, d[0], 1'b1);
      for (int k = 1; k < n; k++)
         ctl.cmd(NOP, b, 12'h000, m, d[k], 1'b1);
   end
   endtask
   task automatic rd(input logic [1:0] b, input logic [8:0] c, input logic [3:0] rm,
      input int n, input logic [31:0] e [4]);
      logic [3:0] oe;
   begin
      ctl.cmd(`SDI_CMD_RD, b, {3'h0, c}, rm, 32'h0, 1'b0);
      ctl.nop(1);
      for (int k = 0; k < n; k++)
      begin
         ctl.nop(1);
         #25;
         oe = (k == 0) ? ~rm : 4'hF;
         chk("rd_oe", {28'h0, oe}, {28'h0, o_data_lines_oe});
         chk("rd_data", e[k] & lanes(oe), o_data_lines & lanes(oe));
      end
      ctl.nop(1);
      #25;
      chk("rd_release", 32'h0, {28'h0, o_data_lines_oe});
   end
   endtask
   initial
   begin
      repeat (20000) @(posedge i_mclk);
      n_mismatch++;
      conclude();
   end
   initial
   begin
      logic [31:0] r;
      logic e;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      i_pwrite <= 1'b0;
      i_paddr <= 8'h00;
      i_pwdata <= 32'h0000_0000;
      repeat (12) @(posedge i_mclk);
      i_reset <= 1'b0;
      rchk("status_rst", `SDI_REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0010);
      rchk("mode_rst", `SDI_REG_MODE, 32'hFFFF_FFFF, 32'h0);
      apb(1'b1, `SDI_REG_CTRL, 32'h1, r, e);
      rchk("ctrl_rw", `SDI_REG_CTRL, 32'hFFFF_FFFF, 32'h1);
      apb(1'b0, 8'h0C, 32'h0, r, e);
      chk("unmapped_err", 32'h1, {31'h0, e});
      chk("unmapped_data", 32'h0, r);
      ctl.power_up(2000, 14'h2020);
      rchk("mode_load", `SDI_REG_MODE, 32'hFFFF_FFFF, 32'h0000_2020);
      rchk("init_done", `SDI_REG_STATUS, 32'h0000_03FF, 32'h0000_01D0);
      // ordinary single-beat cases: preset word, masked overwrite, masked read
      foreach (cases[i])
      begin
         act(cases[i].b, cases[i].row);
         wr(cases[i].b, {3'h0, cases[i].col}, 4'h0, 1, '{32'hA5A5_A5A5, 0, 0, 0});
         wr(cases[i].b, {3'h0, cases[i].col}, cases[i].wm, 1, '{cases[i].wd, 0, 0, 0});
         rd(cases[i].b, cases[i].col, cases[i].rm, 1, '{cases[i].ex, 0, 0, 0});
         pre(cases[i].b, 1'b0);
      end
      act(2'h0, 12'h000);
      rd(2'h0, 9'h000, 4'h0, 1, '{32'h1122_3344, 0, 0, 0});
      // deselected write must leave the word alone
      ctl.cmd(4'hC, 2'h0, 12'h000, 4'h0, 32'h0, 1'b1);
      ctl.nop(1);
      rd(2'h0, 9'h000, 4'h0, 1, '{32'h1122_3344, 0, 0, 0});
      for (int b = 1; b < 4; b++)
         act(b[1:0], 12'h010);
      rchk("banks_open", `SDI_REG_STATUS, 32'h1F, 32'h0F);
      pre(2'h2, 1'b0);
      rchk("pre_one", `SDI_REG_STATUS, 32'h1F, 32'h0B);
      pre(2'h2, 1'b1);
      rchk("pre_all", `SDI_REG_STATUS, 32'h1F, 32'h10);
      act(2'h1, 12'h005);
      wr(2'h1, 12'h403, 4'h0, 1, '{32'h0, 0, 0, 0});
      ctl.nop(2);
      rchk("auto_pre", `SDI_REG_STATUS, 32'h1F, 32'h10);
      lmr(14'h0022);
      act(2'h3, 12'h007);
      wr(2'h3, 12'h001, 4'h0, 4, d4);
      rd(2'h3, 9'h000, 4'h0, 4, '{d4[3], d4[0], d4[1], d4[2]});
      lmr(14'h002A);
      rchk("mode_il", `SDI_REG_MODE, 32'hFFFF_FFFF, 32'h0000_002A);
      act(2'h3, 12'h007);
      rd(2'h3, 9'h001, 4'h0, 4, '{d4[0], d4[3], d4[2], d4[1]});
      // two-beat write with auto precharge closes its bank after the last beat
      lmr(14'h0021);
      act(2'h2, 12'h009);
      wr(2'h2, 12'h404, 4'h0, 2, d4);
      ctl.nop(1);
      rchk("auto_pre_bl2", `SDI_REG_STATUS, 32'h1F, 32'h10);
      // a write sampled while the clock enable is low must not reach the array
      lmr(14'h0020);
      act(2'h0, 12'h000);
      i_cke <= 1'b0;
      ctl.cmd(`SDI_CMD_WR, 2'h0, 12'h000, 4'h0, 32'hFFFF_FFFF, 1'b1);
      ctl.nop(1);
      i_cke <= 1'b1;
      rd(2'h0, 9'h000, 4'h0, 1, '{32'h1122_3344, 0, 0, 0});
      // reset in mid-run closes the open bank and clears mode and control
      @(posedge i_mclk);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_reset <= 1'b0;
      rchk("status_rst2", `SDI_REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0010);
      rchk("ctrl_rst2", `SDI_REG_CTRL, 32'hFFFF_FFFF, 32'h0);
      // with the gate set, a read before start-up completes is refused
      apb(1'b1, `SDI_REG_CTRL, 32'h1, r, e);
      act(2'h0, 12'h000);
      ctl.cmd(`SDI_CMD_RD, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
      ctl.nop(2);
      #25;
      chk("gated_rd", 32'h0, {28'h0, o_data_lines_oe});
      conclude();
   end
endmodule // sdram_init_and_addressing_bench
